// ===== rtl/ext_area_bus_config_regs.sv
// AXI4-Lite register bank that sets width, access states and wait counts per external area.
//
// Overview of operation
// RL1: High/low pair: 01 is 16-bit, 11 8-bit.
// RL2: Width register: high bits upper, low bits lower.
// RL3: Width reset value follows the boot bus width.
// RL4: Software never sets byte-control SRAM areas 8-bit.
// RL5: State bit 0: two states, no waits.
// RL6: State bit 1: three states, waits enabled.
// RL7: State bits upper byte; lower byte reads zero.
// RL8: Two wait registers, four 3-bit fields each.
// RL9: Wait field N inserts N waits when enabled.
// RL10: Eight areas, each with its own select.
// RL11: Addressed area parameters latch at access start.
`timescale 1ns/1ns
module ext_area_bus_config_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Boot strap: high when the device starts on a 16-bit bus
  input wire logic boot_bus_16bit,
  // Register bus
  input wire ext_area_pkg::axil_req_type axil_req,
  output ext_area_pkg::axil_rsp_type axil_rsp,
  // External access sequencer
  input wire logic access_start,
  input wire logic access_end,
  input wire logic [ext_area_pkg::AREA_IDX_W-1:0] access_area,
  output ext_area_pkg::area_cfg_type cur_cfg,
  output logic [ext_area_pkg::NUM_AREAS-1:0] area_select_out
);
  import ext_area_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_AREAS-1:0] width_high_bit;
    logic [NUM_AREAS-1:0] width_low_bit;
    logic [NUM_AREAS-1:0] three_state_select;
    logic [NUM_AREAS-1:0][WAIT_W-1:0] program_wait_count;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [AXI_DATA_W-1:0] rdata;
  } regs_state_type;

  regs_state_type state;
  regs_state_type next_state;
  logic wr_go;
  logic rd_go;
  area_cfg_type [NUM_AREAS-1:0] area_cfg;

  // Both write channels are taken in one edge; a master holding both valids is never stalled forever.
  assign wr_go = axil_req.awvalid && axil_req.wvalid && !state.bvalid;
  assign rd_go = axil_req.arvalid && !state.rvalid;

  // ----------------------------------------------------------------
  // Register behaviour
  // ----------------------------------------------------------------
  always_comb begin
    logic [AXI_DATA_W-1:0] word;
    word = '0;
    next_state = state;
    if (state.bvalid && axil_req.bready) begin
      next_state.bvalid = 1'b0;
    end
    if (state.rvalid && axil_req.rready) begin
      next_state.rvalid = 1'b0;
    end
    if (wr_go) begin
      next_state.bvalid = 1'b1;
      next_state.bresp = RESP_OKAY;
      case ({axil_req.awaddr[AXI_ADDR_W-1:2], 2'b00})
        OFS_BUS_WIDTH: begin
          if (axil_req.wstrb[0]) begin
            next_state.width_low_bit = axil_req.wdata[7:0]; // RL2
          end
          if (axil_req.wstrb[1]) begin
            next_state.width_high_bit = axil_req.wdata[15:8]; // RL2
          end
        end
        OFS_ACCESS_STATE: begin
          // Lower byte has no storage, so writes to it vanish.
          if (axil_req.wstrb[1]) begin
            next_state.three_state_select = axil_req.wdata[15:8]; // RL7
          end
        end
        OFS_WAIT_7_TO_4: begin
          for (int i = 0; i < AREAS_PER_WAIT_REG; i++) begin
            if (axil_req.wstrb[i/2]) begin
              next_state.program_wait_count[AREAS_PER_WAIT_REG+i] = axil_req.wdata[WAIT_STRIDE*i +: WAIT_W]; // RL8
            end
          end
        end
        OFS_WAIT_3_TO_0: begin
          for (int i = 0; i < AREAS_PER_WAIT_REG; i++) begin
            if (axil_req.wstrb[i/2]) begin
              next_state.program_wait_count[i] = axil_req.wdata[WAIT_STRIDE*i +: WAIT_W]; // RL8
            end
          end
        end
        default: begin
          next_state.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (rd_go) begin
      next_state.rvalid = 1'b1;
      next_state.rresp = RESP_OKAY;
      case ({axil_req.araddr[AXI_ADDR_W-1:2], 2'b00})
        OFS_BUS_WIDTH: begin
          word[15:0] = {state.width_high_bit, state.width_low_bit}; // RL2
        end
        OFS_ACCESS_STATE: begin
          word[15:8] = state.three_state_select; // RL7
        end
        OFS_WAIT_7_TO_4: begin
          for (int i = 0; i < AREAS_PER_WAIT_REG; i++) begin
            word[WAIT_STRIDE*i +: WAIT_W] = state.program_wait_count[AREAS_PER_WAIT_REG+i]; // RL8
          end
        end
        OFS_WAIT_3_TO_0: begin
          for (int i = 0; i < AREAS_PER_WAIT_REG; i++) begin
            word[WAIT_STRIDE*i +: WAIT_W] = state.program_wait_count[i]; // RL8
          end
        end
        default: begin
          next_state.rresp = RESP_SLVERR;
        end
      endcase
      next_state.rdata = word;
    end
    if (!aresetn) begin
      next_state = '0;
      // The reset is synchronous, so sampling the strap here is a clocked capture.
      {next_state.width_high_bit, next_state.width_low_bit} =
        boot_bus_16bit ? WIDTH_RESET_BOOT16 : WIDTH_RESET_BOOT8; // RL3
      next_state.three_state_select = STATE_RESET;
      for (int i = 0; i < NUM_AREAS; i++) begin
        next_state.program_wait_count[i] = WAIT_RESET;
      end
    end
  end

  always_ff @(posedge aclk) begin
    state <= next_state;
  end

  assign axil_rsp.awready = wr_go;
  assign axil_rsp.wready = wr_go;
  assign axil_rsp.bvalid = state.bvalid;
  assign axil_rsp.bresp = state.bresp;
  assign axil_rsp.arready = rd_go;
  assign axil_rsp.rvalid = state.rvalid;
  assign axil_rsp.rdata = state.rdata;
  assign axil_rsp.rresp = state.rresp;

  // ----------------------------------------------------------------
  // Per-area decode
  // ----------------------------------------------------------------
  for (genvar n = 0; n < NUM_AREAS; n++) begin : g_area
    // A cleared low bit is prohibited; it is flagged and treated as 8-bit.
    assign area_cfg[n].bus_16bit = state.width_low_bit[n] && !state.width_high_bit[n]; // RL1
    assign area_cfg[n].setting_bad = !state.width_low_bit[n]; // RL1
    assign area_cfg[n].three_state = state.three_state_select[n]; // RL6
    assign area_cfg[n].wait_count = state.three_state_select[n] ? state.program_wait_count[n] : WAIT_NONE; // RL5 RL9
  end

  ext_area_access_select u_select (
    .aclk(aclk),
    .aresetn(aresetn),
    .access_start(access_start),
    .access_end(access_end),
    .access_area(access_area),
    .area_cfg(area_cfg),
    .cur_cfg(cur_cfg),
    .area_select_out(area_select_out)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_read_of(logic [AXI_ADDR_W-1:0] ofs);
    axil_req.arvalid && axil_rsp.arready && ({axil_req.araddr[AXI_ADDR_W-1:2], 2'b00} == ofs);
  endsequence

  sequence s_start_of_area;
    access_start;
  endsequence

  // Checked on the first edge after release, since the default disable hides every edge that reset is low.
  property p_width_reset;
    @(posedge aclk) $rose(aresetn) |-> (axil_rsp.bvalid == 1'b0) &&
      ({state.width_high_bit, state.width_low_bit} == ($past(boot_bus_16bit) ? WIDTH_RESET_BOOT16 : WIDTH_RESET_BOOT8));
  endproperty
  a_width_reset: assert property (p_width_reset) else $error("width reset value ignores boot width"); // RL3

  property p_width_read;
    s_read_of(OFS_BUS_WIDTH) |=> axil_rsp.rvalid && axil_rsp.rdata[15:0] == $past({state.width_high_bit, state.width_low_bit});
  endproperty
  a_width_read: assert property (p_width_read) else $error("width register read back wrong"); // RL2

  property p_state_low_zero;
    s_read_of(OFS_ACCESS_STATE) |=> axil_rsp.rdata[7:0] == 8'h00 && axil_rsp.rdata[15:8] == $past(state.three_state_select);
  endproperty
  a_state_low_zero: assert property (p_state_low_zero) else $error("access state lower byte not zero"); // RL7

  property p_wait_reserved;
    s_read_of(OFS_WAIT_7_TO_4) or s_read_of(OFS_WAIT_3_TO_0) |=>
      axil_rsp.rdata[15] == 1'b0 && axil_rsp.rdata[11] == 1'b0 && axil_rsp.rdata[7] == 1'b0 && axil_rsp.rdata[3] == 1'b0;
  endproperty
  a_wait_reserved: assert property (p_wait_reserved) else $error("wait register reserved bit set"); // RL8

  property p_decode_width;
    s_start_of_area |=> cur_cfg.bus_16bit == ($past(state.width_low_bit[access_area]) && !$past(state.width_high_bit[access_area]));
  endproperty
  a_decode_width: assert property (p_decode_width) else $error("latched bus width wrong"); // RL1

  property p_two_state_no_wait;
    s_start_of_area ##1 !cur_cfg.three_state |-> cur_cfg.wait_count == WAIT_NONE;
  endproperty
  a_two_state_no_wait: assert property (p_two_state_no_wait) else $error("wait inserted in two-state area"); // RL5

  property p_wait_count;
    s_start_of_area |=> cur_cfg.three_state == $past(state.three_state_select[access_area]) &&
      (!cur_cfg.three_state || cur_cfg.wait_count == $past(state.program_wait_count[access_area]));
  endproperty
  a_wait_count: assert property (p_wait_count) else $error("latched wait count wrong"); // RL6 RL9

  property p_hold_until_start;
    !access_start |=> $stable(cur_cfg);
  endproperty
  a_hold_until_start: assert property (p_hold_until_start) else $error("parameters changed mid-access"); // RL11

  property p_select_onehot;
    s_start_of_area |=> $onehot(area_select_out) && area_select_out[$past(access_area)];
  endproperty
  a_select_onehot: assert property (p_select_onehot) else $error("area select not one-hot"); // RL10

  property p_write_answer;
    wr_go |=> axil_rsp.bvalid ##0 (axil_rsp.bvalid && !axil_req.bready) [*1] |=> axil_rsp.bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response dropped before bready");

endmodule : ext_area_bus_config_regs

// ===== rtl/ext_area_pkg.sv
// Shared constants and carrier types for the external area bus configuration registers.
package ext_area_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_AREAS = 8;
  localparam int AREA_IDX_W = 3;
  localparam int WAIT_W = 3;
  localparam int WAIT_STRIDE = 4;
  localparam int AREAS_PER_WAIT_REG = 4;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [AXI_ADDR_W-1:0] OFS_BUS_WIDTH = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFS_ACCESS_STATE = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFS_WAIT_7_TO_4 = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFS_WAIT_3_TO_0 = 8'h0C;
  localparam logic [15:0] WIDTH_RESET_BOOT16 = 16'hFEFF;
  localparam logic [15:0] WIDTH_RESET_BOOT8 = 16'hFFFF;
  localparam logic [7:0] STATE_RESET = 8'hFF;
  localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h7;
  localparam logic [WAIT_W-1:0] WAIT_NONE = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [AXI_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_type;

  typedef struct packed {
    logic bus_16bit;
    logic three_state;
    logic [WAIT_W-1:0] wait_count;
    logic setting_bad;
  } area_cfg_type;

endpackage : ext_area_pkg

// ===== rtl/ext_area_access_select.sv
// Latches the parameters of the addressed area at the start of each external access.
`timescale 1ns/1ns
module ext_area_access_select (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sequencer side
  input wire logic access_start,
  input wire logic access_end,
  input wire logic [ext_area_pkg::AREA_IDX_W-1:0] access_area,
  input wire ext_area_pkg::area_cfg_type [ext_area_pkg::NUM_AREAS-1:0] area_cfg,
  output ext_area_pkg::area_cfg_type cur_cfg,
  output logic [ext_area_pkg::NUM_AREAS-1:0] area_select_out
);
  import ext_area_pkg::*;

  typedef struct packed {
    area_cfg_type cfg;
    logic [NUM_AREAS-1:0] select;
  } sel_state_type;

  sel_state_type state;
  sel_state_type next_state;

  always_comb begin
    next_state = state;
    if (access_end) begin
      next_state.select = '0;
    end
    if (access_start) begin
      // Parameters are sampled only here, so a write mid-access waits for the next one.
      next_state.cfg = area_cfg[access_area]; // RL11
      next_state.select = '0;
      next_state.select[access_area] = 1'b1; // RL10
    end
    if (!aresetn) begin
      next_state = '0;
    end
  end

  always_ff @(posedge aclk) begin
    state <= next_state;
  end

  assign cur_cfg = state.cfg;
  assign area_select_out = state.select;

endmodule : ext_area_access_select

// ===== tb/ext_access_seq_model.sv
// Behavioural external access sequencer that runs accesses with the latched area parameters.
`timescale 1ns/1ns
module ext_access_seq_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control
  input wire logic go,
  input wire logic [2:0] area,
  output logic busy,
  // Block side
  input wire ext_area_pkg::area_cfg_type cur_cfg,
  output logic access_start,
  output logic access_end,
  output logic [2:0] access_area
);
  import ext_area_pkg::*;
  logic [3:0] left;
  // The area index is scrambled between starts so that a stale value is never latched by luck.
  always_ff @(posedge aclk) begin
    access_start <= 1'b0;
    access_end <= 1'b0;
    access_area <= ~access_area;
    if (!aresetn) begin
      busy <= 1'b0;
      left <= 4'h0;
      access_area <= 3'h0;
    end else if (go && !busy) begin
      access_start <= 1'b1;
      access_area <= area;
      busy <= 1'b1;
      left <= 4'hF;
    end else if (busy && left == 4'hF) begin
      left <= 4'hE;
    end else if (busy && left == 4'hE) begin
      left <= (cur_cfg.three_state ? 4'h3 : 4'h2) + 4'(cur_cfg.wait_count);
    end else if (busy && left != 4'h0) begin
      left <= left - 4'h1;
    end else if (busy) begin
      access_end <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule : ext_access_seq_model

// ===== tb/tb_ext_area_bus_config_regs.sv
// Self-checking bench for the external area bus configuration registers.
`timescale 1ns/1ns
module tb_ext_area_bus_config_regs;
  import ext_area_pkg::*;
  logic aclk;
  logic aresetn;
  logic boot;
  logic go;
  logic [2:0] area;
  logic busy;
  logic seq_start;
  logic seq_end;
  logic [2:0] seq_area;
  axil_req_type req;
  axil_rsp_type rsp;
  area_cfg_type cfg;
  logic [7:0] sel;
  int fail_count = 0;
  int n_tests = 0;
  logic [15:0] e_wid;
  logic [7:0] e_sta;
  logic [15:0] e_wa;
  logic [15:0] e_wb;
  logic [1:0] resp;
  logic [31:0] data;

  ext_area_bus_config_regs ext_area_bus_config_regs_i (.aclk(aclk), .aresetn(aresetn), .boot_bus_16bit(boot),
    .axil_req(req), .axil_rsp(rsp), .access_start(seq_start), .access_end(seq_end), .access_area(seq_area),
    .cur_cfg(cfg), .area_select_out(sel));
  ext_access_seq_model ext_access_seq_model_i (.aclk(aclk), .aresetn(aresetn), .go(go), .area(area),
    .busy(busy), .cur_cfg(cfg), .access_start(seq_start), .access_end(seq_end), .access_area(seq_area));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic pick(input int k);
    case (k)
      0: return rsp.awready;
      1: return rsp.bvalid;
      2: return rsp.arready;
      3: return rsp.rvalid;
      4: return seq_start;
      default: return seq_end;
    endcase
  endfunction : pick

  // Values are looked at in the active region of the edge, before that edge's updates land.
  task automatic wait_for(input int k);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (pick(k) !== 1'b1 && n < 60);
    if (n >= 60) begin
      fail_count++;
      $display("Error at %0t: handshake timeout", $time);
    end
  endtask : wait_for

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    wait_for(0);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    wait_for(1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    wait_for(2);
    req.arvalid <= 1'b0;
    wait_for(3);
    resp = rsp.rresp;
    data = rsp.rdata;
    req.rready <= 1'b0;
  endtask : axi_read

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    axi_read(a);
    check(data, {16'h0000, exp});
    check(resp, RESP_OKAY);
  endtask : rd

  task automatic do_reset(input logic strap);
    @(posedge aclk);
    aresetn <= 1'b0;
    boot <= strap;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    e_wid = strap ? 16'hFEFF : 16'hFFFF;
    e_sta = 8'hFF;
    e_wa = 16'h7777;
    e_wb = 16'h7777;
  endtask : do_reset

  function automatic logic [31:0] exp_cfg(input int n);
    logic lo;
    logic hi;
    logic st;
    logic [15:0] w;
    lo = e_wid[n];
    hi = e_wid[8 + n];
    st = e_sta[n];
    w = n > 3 ? e_wa >> (4 * (n - 4)) : e_wb >> (4 * n);
    return {26'h0, lo & !hi, st, st ? w[2:0] : 3'h0, !lo};
  endfunction : exp_cfg

  task automatic do_access(input int n);
    @(posedge aclk);
    go <= 1'b1;
    area <= 3'(n);
    wait_for(4);
    go <= 1'b0;
    @(posedge aclk);
    check(cfg, exp_cfg(n));
    check(sel, 8'h01 << n);
    wait_for(5);
    @(posedge aclk);
    check(sel, 8'h00);
  endtask : do_access

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial begin
    req = '0;
    aresetn = 1'b0;
    boot = 1'b1;
    go = 1'b0;
    area = 3'h0;
    do_reset(1'b1);
    rd(OFS_BUS_WIDTH, 16'hFEFF);
    rd(OFS_ACCESS_STATE, 16'hFF00);
    rd(OFS_WAIT_7_TO_4, 16'h7777);
    rd(OFS_WAIT_3_TO_0, 16'h7777);
    do_access(0);
    $display("Test reset values done");
    // No area here is a byte-control SRAM, so 8-bit settings are allowed.
    axi_write(OFS_BUS_WIDTH, 32'hABCD0AFE, 4'h2);
    rd(OFS_BUS_WIDTH, 16'h0AFF);
    axi_write(OFS_BUS_WIDTH, 32'hABCD0AFE, 4'h1);
    rd(OFS_BUS_WIDTH, 16'h0AFE);
    axi_write(OFS_ACCESS_STATE, 32'h00005AFF, 4'h3);
    rd(OFS_ACCESS_STATE, 16'h5A00);
    axi_write(OFS_WAIT_7_TO_4, 32'h0000FEDC, 4'h3);
    rd(OFS_WAIT_7_TO_4, 16'h7654);
    axi_write(OFS_WAIT_3_TO_0, 32'h0000B3A8, 4'h3);
    rd(OFS_WAIT_3_TO_0, 16'h3320);
    e_wid = 16'h0AFE;
    e_sta = 8'h5A;
    e_wa = 16'h7654;
    e_wb = 16'h3320;
    $display("Test register writes done");
    for (int n = 0; n < NUM_AREAS; n++) begin
      do_access(n);
    end
    $display("Test area accesses done");
    axi_write(8'h10, 32'h0000FFFF, 4'hF);
    check(resp, RESP_SLVERR);
    axi_read(8'h10);
    check(resp, RESP_SLVERR);
    check(data, 32'h0);
    $display("Test unmapped offset done");
    do_reset(1'b0);
    rd(OFS_BUS_WIDTH, 16'hFFFF);
    do_access(0);
    $display("Test eight-bit boot done");
    give_verdict();
  end
endmodule : tb_ext_area_bus_config_regs
